// [logic/tape_dump_consts.svh]
// timing, framing and reset constants for the tape dump block
// assumes a 20 MHz system clock and frame layout start, 8 data, parity, stop
`ifndef TAPE_DUMP_CONSTS_SVH
`define TAPE_DUMP_CONSTS_SVH
`define CLOCK_HZ 20000000
`define TRANSFER_S 10
`define FULL_WORDS 256
`define EXT_WORDS 512
`define FRAME_BITS 11
`define MARK_HZ 2400
`define SPACE_HZ 1200
`define GATE_US 1000
`define MARK_RUN 5'h10
`define IDLE_FRAMES 2
`define START_BIT 1'b0
`define STOP_BIT 1'b1
`define TAPE_RESET 1'b0
`endif

// [logic/tape_dump_pkg.sv]
// types shared by the tape dump block
// assumes nothing beyond the consts header
package tape_dump_pkg;
  typedef struct packed {
    logic [1:0] code;
    logic [5:0] pitch;
  } word_t;
  typedef struct packed {
    logic mode_pgm;
    logic proceed;
    logic stop;
    logic len512;
    logic [2:0] digital;
    logic [5:0] pitch;
  } pins_t;
  typedef enum logic [2:0] {
    CTL_IDLE, CTL_SAMPLE, CTL_GATE, CTL_SETTLE, CTL_DRAIN, CTL_LISTEN, CTL_WRITE, CTL_DONE
  } ctl_t;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_t;
endpackage

// [logic/word_fifo.sv]
// word fifo with valid/ready on both sides
// assumes one clock; ready on the fill side drops when full
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_shape
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  always_comb begin
    in_ready_out = (wr_q ^ rd_q) != {1'b1, AW'(0)};
    out_valid_out = wr_q != rd_q;
    out_data_out = mem_q[rd_q[AW-1:0]];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// [logic/tone_detect.sv]
// half-period tone classifier for the tape input
// assumes tape_in is a squared-up line signal from outside the clock domain
module tone_detect #(
  parameter logic [23:0] THRESH = 24'h00_186a,
  parameter logic [23:0] LOST = 24'h00_411a
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic tape_in,
  output logic tone_mark_out,
  output logic strobe_out,
  output logic carrier_out
);
  logic sync1_q, sync2_q, prev_q;
  logic [23:0] cnt_q, cnt_d;
  logic mark_q, mark_d, strobe_q, strobe_d, carrier_q, carrier_d;
  always_comb begin
    cnt_d = (cnt_q < LOST) ? cnt_q + 24'h00_0001 : cnt_q;
    mark_d = mark_q;
    strobe_d = 1'b0;
    carrier_d = carrier_q && cnt_q < LOST;
    if (sync2_q != prev_q) begin
      cnt_d = 24'h00_0001;
      // a gap of two space half periods or more only restarts timing
      if (cnt_q < LOST) begin
        mark_d = cnt_q < THRESH;
        strobe_d = 1'b1;
        carrier_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      cnt_q <= '0;
      mark_q <= 1'b1;
      strobe_q <= 1'b0;
      carrier_q <= 1'b0;
    end else begin
      sync1_q <= tape_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      cnt_q <= cnt_d;
      mark_q <= mark_d;
      strobe_q <= strobe_d;
      carrier_q <= carrier_d;
    end
  end
  assign tone_mark_out = mark_q;
  assign strobe_out = strobe_q;
  assign carrier_out = carrier_q;
endmodule

// [logic/tape_dump.sv]
// tape dump sequencer: saves sequencer memory words to tape and restores them
// assumes all switch, button, memory and tape inputs are asynchronous pins
//
// How it works
// - in record mode a transfer starts only on a press of the proceed button.
// - a full 256-word memory is sent in about 10 s, each word taking a fixed frame time.
// - when the last record word has gone out the done lamp lights and stays lit.
// - in record mode a high early-stop input on the current address makes that word the last one.
// - the transfer length is 256 words, or 512 when the length select is set.
// - in record mode read-back words are compared with sent words and a mismatch lights error.
// - the gate output pulses once per transferred word to step the address counter.
// - in program mode the mark lamp lights while the idle mark tone is heard.
// - in program mode done lights after the data stream ends, error if any word was bad.
// - the programmer is inhibited while program mode is selected and freed in record.
// - a word carries a 6-bit pitch value plus a 2-bit digital code.
// - the code is one of four values, the fourth when no digital input is high.
`include "tape_dump_consts.svh"
module tape_dump
  import tape_dump_pkg::*;
#(
  parameter logic [23:0] BIT_CYCLES =
    24'(`CLOCK_HZ * `TRANSFER_S / (`FULL_WORDS * `FRAME_BITS)),
  parameter logic [23:0] MARK_HALF = 24'(`CLOCK_HZ / (2 * `MARK_HZ)),
  parameter logic [23:0] SPACE_HALF = 24'(`CLOCK_HZ / (2 * `SPACE_HZ)),
  parameter logic [23:0] GATE_CYCLES = 24'((`CLOCK_HZ / 1000 * `GATE_US + 999) / 1000),
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic program_record_select_in,
  input wire logic proceed_in,
  input wire logic stop_in,
  input wire logic length_512_in,
  input wire logic [5:0] pitch_in,
  input wire logic [2:0] digital_in,
  input wire logic tape_in,
  output logic tape_out,
  output logic gate_out,
  output logic write_out,
  output logic [5:0] rx_pitch_out,
  output logic [2:0] rx_digital_out,
  output logic mark_lamp_out,
  output logic done_lamp_out,
  output logic error_lamp_out,
  output logic programmer_inhibit_out
);
  localparam logic [23:0] IDLE_CYCLES = 24'(BIT_CYCLES * `FRAME_BITS * `IDLE_FRAMES);
  localparam logic [23:0] FRAME_CYC = 24'(BIT_CYCLES * `FRAME_BITS);
  localparam logic [23:0] THRESH = MARK_HALF + ((SPACE_HALF - MARK_HALF) >> 1);
  if (MARK_HALF < 2 || SPACE_HALF <= MARK_HALF || BIT_CYCLES < 2 * SPACE_HALF
      || GATE_CYCLES == 0 || SPACE_HALF > 24'h3f_ffff) begin : bad_timing
    $error("tape timing parameters out of range");
  end

  function automatic logic [1:0] code_of(input logic [2:0] d);
    if (d[0]) return 2'h0;
    if (d[1]) return 2'h1;
    if (d[2]) return 2'h2;
    return 2'h3;
  endfunction
  function automatic logic [2:0] lines_of(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h1 << c;
  endfunction
  function automatic logic [9:0] limit_of(input logic l512);
    return l512 ? 10'(`EXT_WORDS) : 10'(`FULL_WORDS);
  endfunction
  function automatic logic [`FRAME_BITS-1:0] frame_of(input word_t w);
    return {`STOP_BIT, ^w, w, `START_BIT};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  pins_t pins_in, sync1_q, sync2_q;
  logic proceed_prev_q, start, rec_run, pgm_run;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, push_valid, ser_take;
  word_t fifo_out_data, push_data, sample_word;
  logic tone_mark, tone_strobe, carrier;
  // button bounce is harmless: a press only starts a transfer while idle or done
  always_comb begin
    pins_in = {program_record_select_in, proceed_in, stop_in, length_512_in,
               digital_in, pitch_in};
    start = sync2_q.proceed && !proceed_prev_q;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      proceed_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      proceed_prev_q <= sync2_q.proceed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ctl_t ctl_q, ctl_d;
  logic [9:0] words_q, words_d;
  logic [23:0] timer_q, timer_d, idle_q, idle_d;
  logic last_q, last_d, mode_q, mode_d, got_q, got_d, gate_q, gate_d, write_q, write_d;
  logic [5:0] rx_pitch_q, rx_pitch_d;
  logic [2:0] rx_dig_q, rx_dig_d;
  logic ser_busy_q, rx_valid_q, rx_bad_q;
  word_t rx_word_q, sent_q;
  always_comb begin
    ctl_d = ctl_q;
    words_d = words_q;
    timer_d = timer_q;
    last_d = last_q;
    mode_d = mode_q;
    got_d = got_q;
    rx_pitch_d = rx_pitch_q;
    rx_dig_d = rx_dig_q;
    sample_word = '{code: code_of(sync2_q.digital), pitch: sync2_q.pitch};
    rec_run = !mode_q && ctl_q != CTL_IDLE && ctl_q != CTL_DONE;
    pgm_run = mode_q && ctl_q != CTL_IDLE && ctl_q != CTL_DONE;
    push_valid = (ctl_q == CTL_SAMPLE) || (pgm_run && rx_valid_q);
    push_data = (ctl_q == CTL_SAMPLE) ? sample_word : rx_word_q;
    fifo_out_ready = mode_q ? ctl_q == CTL_LISTEN : rec_run && !ser_busy_q;
    ser_take = rec_run && fifo_out_valid && fifo_out_ready;
    idle_d = (rx_valid_q || idle_q >= IDLE_CYCLES) ? (rx_valid_q ? '0 : idle_q)
                                                   : idle_q + 24'h00_0001;
    if (pgm_run && rx_valid_q) begin
      got_d = 1'b1;
    end
    unique case (ctl_q)
      CTL_IDLE, CTL_DONE: if (start) begin
        mode_d = sync2_q.mode_pgm;
        ctl_d = sync2_q.mode_pgm ? CTL_LISTEN : CTL_SAMPLE;
        words_d = '0;
        last_d = 1'b0;
        got_d = 1'b0;
        idle_d = '0;
      end
      CTL_SAMPLE: if (fifo_in_ready) begin
        words_d = words_q + 10'h001;
        last_d = sync2_q.stop || words_d == limit_of(sync2_q.len512);
        timer_d = GATE_CYCLES;
        ctl_d = CTL_GATE;
      end
      CTL_LISTEN: if (fifo_out_valid) begin
        rx_pitch_d = fifo_out_data.pitch;
        rx_dig_d = lines_of(fifo_out_data.code);
        words_d = words_q + 10'h001;
        last_d = words_d == limit_of(sync2_q.len512);
        timer_d = GATE_CYCLES;
        ctl_d = CTL_WRITE;
      end else if (got_q && idle_q >= IDLE_CYCLES) begin
        ctl_d = CTL_DONE;
      end
      CTL_GATE, CTL_SETTLE, CTL_WRITE: if (timer_q > 24'h00_0001) begin
        timer_d = timer_q - 24'h00_0001;
      end else begin
        timer_d = GATE_CYCLES;
        if (ctl_q == CTL_WRITE) begin
          ctl_d = CTL_GATE;
        end else if (ctl_q == CTL_GATE) begin
          ctl_d = CTL_SETTLE;
        end else if (last_q) begin
          ctl_d = mode_q ? CTL_DONE : CTL_DRAIN;
        end else begin
          ctl_d = mode_q ? CTL_LISTEN : CTL_SAMPLE;
        end
      end
      CTL_DRAIN: if (!fifo_out_valid && !ser_busy_q) begin
        ctl_d = CTL_DONE;
      end
    endcase
    gate_d = ctl_d == CTL_GATE;
    write_d = ctl_d == CTL_WRITE;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctl_q <= CTL_IDLE;
      words_q <= '0;
      timer_q <= '0;
      idle_q <= '0;
      last_q <= 1'b0;
      mode_q <= 1'b0;
      got_q <= 1'b0;
      gate_q <= 1'b0;
      write_q <= 1'b0;
      rx_pitch_q <= '0;
      rx_dig_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      words_q <= words_d;
      timer_q <= timer_d;
      idle_q <= idle_d;
      last_q <= last_d;
      mode_q <= mode_d;
      got_q <= got_d;
      gate_q <= gate_d;
      write_q <= write_d;
      rx_pitch_q <= rx_pitch_d;
      rx_dig_q <= rx_dig_d;
    end
  end

  // record side keeps the sampler up to eight words ahead of the tape
  word_fifo #(.WIDTH($bits(word_t)), .DEPTH(FIFO_DEPTH)) buffer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic ser_busy_d, tape_q, tape_d, cur_mark;
  logic [`FRAME_BITS-1:0] frame_q, frame_d;
  logic [3:0] bit_q, bit_d;
  logic [23:0] btimer_q, btimer_d, half_q, half_d, half_len, fcnt_q;
  word_t sent_d;
  always_comb begin
    ser_busy_d = ser_busy_q;
    frame_d = frame_q;
    bit_d = bit_q;
    btimer_d = btimer_q;
    sent_d = sent_q;
    if (ser_take) begin
      ser_busy_d = 1'b1;
      frame_d = frame_of(fifo_out_data);
      bit_d = '0;
      btimer_d = BIT_CYCLES;
      sent_d = fifo_out_data;
    end else if (ser_busy_q) begin
      if (btimer_q > 24'h00_0001) begin
        btimer_d = btimer_q - 24'h00_0001;
      end else begin
        btimer_d = BIT_CYCLES;
        frame_d = frame_q >> 1;
        if (bit_q == 4'(`FRAME_BITS - 1)) begin
          ser_busy_d = 1'b0;
        end else begin
          bit_d = bit_q + 4'h1;
        end
      end
    end
    // idle line carries the mark tone so the receiver can lock before data
    cur_mark = !ser_busy_q || frame_q[0];
    half_len = cur_mark ? MARK_HALF : SPACE_HALF;
    tape_d = tape_q;
    half_d = half_q + 24'h00_0001;
    if (half_d >= half_len) begin
      half_d = '0;
      tape_d = !tape_q;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ser_busy_q <= 1'b0;
      frame_q <= '1;
      bit_q <= '0;
      btimer_q <= '0;
      sent_q <= '0;
      half_q <= '0;
      tape_q <= `TAPE_RESET;
      fcnt_q <= '0;
    end else begin
      ser_busy_q <= ser_busy_d;
      frame_q <= frame_d;
      bit_q <= bit_d;
      btimer_q <= btimer_d;
      sent_q <= sent_d;
      half_q <= half_d;
      tape_q <= tape_d;
      fcnt_q <= ser_busy_q ? fcnt_q + 24'h00_0001 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  tone_detect #(.THRESH(THRESH), .LOST({SPACE_HALF[22:0], 1'b0})) detect (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tape_in(tape_in),
    .tone_mark_out(tone_mark),
    .strobe_out(tone_strobe),
    .carrier_out(carrier)
  );
  rx_t rx_q, rx_d;
  logic [9:0] shift_q, shift_d;
  logic [3:0] rbit_q, rbit_d;
  logic [23:0] rtimer_q, rtimer_d;
  logic rx_valid_d, rx_bad_d, line_bit;
  word_t rx_word_d, cmp_q, cmp_d;
  always_comb begin
    rx_d = rx_q;
    shift_d = shift_q;
    rbit_d = rbit_q;
    rtimer_d = rtimer_q;
    rx_valid_d = 1'b0;
    rx_bad_d = rx_bad_q;
    rx_word_d = rx_word_q;
    cmp_d = cmp_q;
    line_bit = tone_mark && carrier;
    unique case (rx_q)
      RX_HUNT: if (carrier && !tone_mark) begin
        rx_d = RX_START;
        // sent_q moves on before the read-back frame ends
        cmp_d = sent_q;
        rtimer_d = BIT_CYCLES >> 1;
      end
      RX_START: if (rtimer_q > 24'h00_0001) begin
        rtimer_d = rtimer_q - 24'h00_0001;
      end else if (line_bit) begin
        rx_d = RX_HUNT;
      end else begin
        rx_d = RX_BITS;
        rtimer_d = BIT_CYCLES;
        rbit_d = '0;
      end
      RX_BITS: if (rtimer_q > 24'h00_0001) begin
        rtimer_d = rtimer_q - 24'h00_0001;
      end else begin
        rtimer_d = BIT_CYCLES;
        shift_d = {line_bit, shift_q[9:1]};
        if (rbit_q == 4'(`FRAME_BITS - 2)) begin
          rx_d = RX_HUNT;
          rx_valid_d = 1'b1;
          rx_word_d = shift_d[7:0];
          rx_bad_d = !shift_d[9] || (^shift_d[8:0]);
        end else begin
          rbit_d = rbit_q + 4'h1;
        end
      end
      default: rx_d = RX_HUNT;
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_q <= RX_HUNT;
      shift_q <= '0;
      rbit_q <= '0;
      rtimer_q <= '0;
      rx_valid_q <= 1'b0;
      rx_bad_q <= 1'b0;
      rx_word_q <= '0;
      cmp_q <= '0;
    end else begin
      rx_q <= rx_d;
      shift_q <= shift_d;
      rbit_q <= rbit_d;
      rtimer_q <= rtimer_d;
      rx_valid_q <= rx_valid_d;
      rx_bad_q <= rx_bad_d;
      rx_word_q <= rx_word_d;
      cmp_q <= cmp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] run_q, run_d;
  logic mark_q, mark_d, done_q, done_d, error_q, error_d, inhibit_q, inhibit_d, err_ev;
  always_comb begin
    run_d = run_q;
    if (!carrier) begin
      run_d = '0;
    end else if (tone_strobe) begin
      run_d = !tone_mark ? '0 : (run_q == `MARK_RUN) ? run_q : run_q + 5'h01;
    end
    mark_d = sync2_q.mode_pgm && carrier && run_q == `MARK_RUN;
    inhibit_d = sync2_q.mode_pgm;
    // the event wins over the clear taken from a fresh start
    done_d = (done_q && !start) || (ctl_q != CTL_DONE && ctl_d == CTL_DONE);
    err_ev = (rec_run && rx_valid_q && (rx_bad_q || rx_word_q != cmp_q))
          || (pgm_run && rx_valid_q && (rx_bad_q || !fifo_in_ready));
    error_d = (error_q && !start) || err_ev;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_q <= '0;
      mark_q <= 1'b0;
      done_q <= 1'b0;
      error_q <= 1'b0;
      inhibit_q <= 1'b0;
    end else begin
      run_q <= run_d;
      mark_q <= mark_d;
      done_q <= done_d;
      error_q <= error_d;
      inhibit_q <= inhibit_d;
    end
  end
  assign tape_out = tape_q;
  assign gate_out = gate_q;
  assign write_out = write_q;
  assign rx_pitch_out = rx_pitch_q;
  assign rx_digital_out = rx_dig_q;
  assign mark_lamp_out = mark_q;
  assign done_lamp_out = done_q;
  assign error_lamp_out = error_q;
  assign programmer_inhibit_out = inhibit_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  start_on_press_a: assert property ((ctl_q == CTL_SAMPLE && $past(ctl_q) inside
    {CTL_IDLE, CTL_DONE}) |-> $past(start)) else $error("record began without press");
  frame_length_a: assert property ($fell(ser_busy_q) |-> fcnt_q == FRAME_CYC)
    else $error("tape frame length wrong");
  done_after_drain_a: assert property ((ctl_q == CTL_DRAIN ##1 ctl_q == CTL_DONE)
    |-> done_q ##1 done_q) else $error("done lamp not lit after record");
  early_stop_a: assert property ((ctl_q == CTL_SAMPLE && fifo_in_ready && sync2_q.stop)
    |=> last_q ##[1:2] ctl_q == CTL_GATE) else $error("early stop ignored");
  length_end_a: assert property ((ctl_q == CTL_SAMPLE && fifo_in_ready &&
    words_q + 10'h001 == limit_of(sync2_q.len512)) |=> last_q) else $error("length not honoured");
  verify_error_a: assert property ((rec_run && rx_valid_q && rx_word_q != cmp_q)
    |=> error_q) else $error("read-back mismatch not flagged");
  gate_per_word_a: assert property ($rose(gate_q) |-> $past(ctl_q) == CTL_SAMPLE
    || $past(ctl_q) == CTL_WRITE) else $error("gate without a word");
  mark_lamp_mode_a: assert property (mark_q |-> $past(sync2_q.mode_pgm))
    else $error("mark lamp outside program mode");
  stream_end_a: assert property ((ctl_q == CTL_LISTEN && got_q && idle_q >= IDLE_CYCLES
    && !fifo_out_valid) |=> ctl_q == CTL_DONE ##1 done_q) else $error("stream end missed");
  inhibit_mode_a: assert property (sync2_q.mode_pgm [*2] |-> inhibit_q)
    else $error("programmer not inhibited");
  code_none_a: assert property ((ctl_q == CTL_SAMPLE && sync2_q.digital == 3'h0)
    |-> push_data.code == 2'h3) else $error("fourth code not chosen");
  rec_done_c: cover property (ctl_q == CTL_DRAIN ##1 ctl_q == CTL_DONE);
  pgm_done_c: cover property (ctl_q == CTL_LISTEN ##1 ctl_q == CTL_DONE);
  error_lamp_c: cover property ($rose(error_q));
endmodule

// [testbench/tape_partner.sv]
// tape recorder and sequencer memory model facing the tape dump block
// assumes the bench fills mem, clears the address and drives prog_in and jam_in
module tape_partner
  import tape_dump_pkg::*;
#(
  parameter int BIT = 16,
  parameter int MARK_H = 3,
  parameter int SPACE_H = 6
) (
  input wire logic clock_in,
  input wire logic gate_in,
  input wire logic tape_line_in,
  input wire logic prog_in,
  input wire logic jam_in,
  input wire logic [9:0] stop_addr_in,
  output logic [5:0] pitch_out,
  output logic [2:0] digital_out,
  output logic stop_out,
  output logic tape_out
);
  timeunit 1ns;
  timeprecision 1ns;
  word_t mem [0:511];
  int addr = 0;
  int gate_cnt = 0;
  int hc = 0;
  logic gate_q = 1'b0;
  logic lb = 1'b0;
  logic fsk = 1'b0;
  logic tone = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // memory side: word patched to the programmer inputs, one-hot digital lines, none for code 3
  assign pitch_out = mem[addr[8:0]].pitch;
  assign digital_out = (mem[addr[8:0]].code == 2'h3) ? 3'h0 : 3'(1 << mem[addr[8:0]].code);
  assign stop_out = (addr[9:0] == stop_addr_in);
  // jam holds the line low: a dropout, so read-back frames break
  assign tape_out = prog_in ? fsk : (jam_in ? 1'b0 : lb);
  always @(negedge clock_in) begin
    gate_q <= gate_in;
    lb <= tape_line_in;
    if (gate_in && !gate_q) begin
      addr <= addr + 1;
      gate_cnt <= gate_cnt + 1;
    end
    if (hc >= (tone ? MARK_H : SPACE_H) - 1) begin
      fsk <= !fsk;
      hc <= 0;
    end else begin
      hc <= hc + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic clear_addr();
    addr = 0;
    gate_cnt = 0;
  endtask
  // lsb first: start space, pitch, code, even parity, stop mark
  task automatic send_word(input word_t w, input bit bad);
    logic [10:0] f;
    f = {1'b1, (^w) ^ bad, w, 1'b0};
    for (int i = 0; i < 11; i++) begin
      tone = f[i];
      repeat (BIT) @(negedge clock_in);
    end
    tone = 1'b1;
  endtask
endmodule

// [testbench/tape_dump_tb_top.sv]
// self-checking bench for the tape dump block with shortened tone and gate counts
// assumes the tape_partner model for memory, address counter and recorder
module tape_dump_tb_top
  import tape_dump_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16;
  logic clock_in, rst_in, mode, proceed, len512, jam, stop_in, tape_in;
  logic tape_out, gate_out, write_out, mark_lamp, done_lamp, error_lamp, inhibit;
  logic [9:0] stop_addr;
  logic [5:0] pitch_in, rx_pitch;
  logic [2:0] digital_in, rx_digital;
  logic [8:0] q[$];
  logic wr_q = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  int n_wr = 0;
  tape_dump #(.BIT_CYCLES(24'h00_0010), .MARK_HALF(24'h00_0003), .SPACE_HALF(24'h00_0006),
    .GATE_CYCLES(24'h00_0003)) uut (.clock_in(clock_in), .rst_in(rst_in),
    .program_record_select_in(mode), .proceed_in(proceed), .stop_in(stop_in),
    .length_512_in(len512), .pitch_in(pitch_in), .digital_in(digital_in), .tape_in(tape_in),
    .tape_out(tape_out), .gate_out(gate_out), .write_out(write_out), .rx_pitch_out(rx_pitch),
    .rx_digital_out(rx_digital), .mark_lamp_out(mark_lamp), .done_lamp_out(done_lamp),
    .error_lamp_out(error_lamp), .programmer_inhibit_out(inhibit));
  tape_partner #(.BIT(BIT)) p (.clock_in(clock_in),
    .gate_in(gate_out), .tape_line_in(tape_out), .prog_in(mode), .jam_in(jam),
    .stop_addr_in(stop_addr), .pitch_out(pitch_in), .digital_out(digital_in),
    .stop_out(stop_in), .tape_out(tape_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [2:0] exp_dig(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'(1 << c);
  endfunction
  // button held past the two-stage synchronizer, then released
  task automatic press();
    proceed = 1'b1;
    repeat (6) @(negedge clock_in);
    proceed = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask
  task automatic wait_done(output int dur);
    dur = 0;
    while (done_lamp !== 1'b1) begin
      @(negedge clock_in);
      dur++;
      if (dur > 60000) begin
        err_count++;
        $display("[ERR] done_wait expected 1 seen %b", done_lamp);
        give_verdict();
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // writer monitor: every strobe, except for a word sent with bad parity, must present the next queued word
  always @(negedge clock_in) begin
    wr_q <= write_out;
    if (write_out === 1'b1 && wr_q !== 1'b1) begin
      n_wr++;
      if (q.size() > 0 && !q[0][8]) begin
        check("rx_pitch", rx_pitch, q[0][5:0]);
        check("rx_digital", rx_digital, exp_dig(q[0][7:6]));
      end
      if (q.size() > 0)
        void'(q.pop_front());
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic record_run(input logic l5, input logic [9:0] sa, input logic jm,
                            input int ng, input logic er);
    int dur;
    len512 = l5;
    stop_addr = sa;
    p.clear_addr();
    press();
    if (jm) begin
      repeat (60) @(negedge clock_in);
      jam = 1'b1;
      repeat (100) @(negedge clock_in);
      jam = 1'b0;
    end
    wait_done(dur);
    check("gate_count", 16'(p.gate_cnt), 16'(ng));
    check("record_error", error_lamp, 16'(er));
    if (ng == 256)
      check("full_duration", 16'(dur >= 256 * 11 * BIT && dur <= 256 * (11 * BIT + 4) + 200),
            16'h0001);
    repeat (50) @(negedge clock_in);
    check("done_held", done_lamp, 16'h0001);
  endtask
  task automatic program_run(input bit bad);
    int dur;
    word_t w;
    p.clear_addr();
    n_wr = 0;
    press();
    repeat (100) @(negedge clock_in);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : word_t'($urandom);
      q.push_back({bad && i == 2, w});
      p.send_word(w, bad && i == 2);
    end
    wait_done(dur);
    check("write_count", 16'(n_wr), 16'h0004);
    check("prog_gates", 16'(p.gate_cnt), 16'h0004);
    check("prog_error", error_lamp, 16'(bad));
  endtask
  initial begin
    rst_in = 1'b1;
    mode = 1'b0;
    proceed = 1'b0;
    len512 = 1'b0;
    jam = 1'b0;
    stop_addr = 10'h3ff;
    void'($urandom(83673));
    for (int i = 0; i < 512; i++)
      p.mem[i] = word_t'($urandom);
    repeat (3) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (200) @(negedge clock_in);
    check("gate_before_press", 16'(p.gate_cnt), 16'h0000);
    check("inhibit_record", inhibit, 16'h0000);
    record_run(1'b0, 10'h005, 1'b0, 6, 1'b0);
    record_run(1'b0, 10'h3ff, 1'b0, 256, 1'b0);
    record_run(1'b1, 10'h101, 1'b0, 258, 1'b0);
    record_run(1'b0, 10'h002, 1'b1, 3, 1'b1);
    mode = 1'b1;
    repeat (200) @(negedge clock_in);
    check("mark_lamp", mark_lamp, 16'h0001);
    check("inhibit_program", inhibit, 16'h0001);
    program_run(1'b0);
    program_run(1'b1);
    mode = 1'b0;
    repeat (10) @(negedge clock_in);
    check("inhibit_back", inhibit, 16'h0000);
    check("mark_off", mark_lamp, 16'h0000);
    give_verdict();
  end
endmodule
